/* smc_core_model.sv */
// Model of the core and of one level interrupt source on external line 2.
// Assumes the bench asks for sleep and wake with one-cycle request pulses.
`timescale 1ns/1ps
module smc_core_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bench requests
   input wire logic go_sleep,
   input wire logic go_wake,
   // Device side
   input wire logic core_run,
   input wire logic irq_take,
   output logic sleep_cmd,
   output logic ext_irq_line_2
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sleep_cmd <= 1'b0;
      end else begin
         sleep_cmd <= go_sleep && core_run;
      end
   end
   // The level is held until the interrupt is taken, so a slow wake is never missed.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_irq_line_2 <= 1'b0;
      end else if (irq_take) begin
         ext_irq_line_2 <= 1'b0;
      end else if (go_wake) begin
         ext_irq_line_2 <= 1'b1;
      end
   end
endmodule

/* smc_pkg.sv */
// Constants for the sleep mode controller: register map, field layout, mode codes, timing.
// Assumes a 125 MHz pclk; all times are converted to pclk cycles here.
package smc_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] SMC_OFF_CTRL = 8'h00;
   localparam logic [7:0] SMC_OFF_CFG = 8'h04;
   localparam logic [7:0] SMC_OFF_STATUS = 8'h08;
   localparam logic [7:0] SMC_CTRL_RESET = 8'h00;
   localparam logic [7:0] SMC_CFG_RESET = 8'h00;
   localparam int SMC_SE_POS = 7;
   localparam int SMC_SM_MSB = 6;
   localparam int SMC_SM_LSB = 4;
   // Configuration word: clock source fuses [3:0], startup fuses [5:4], crystal flag [6],
   // ADC enable [7], timer 2 async clock [8].
   localparam int SMC_CFG_CLOCK_SOURCE_FUSES_LSB = 0;
   localparam int SMC_CFG_SUT_LSB = 4;
   localparam int SMC_CFG_XTAL_POS = 6;
   localparam int SMC_CFG_ADCEN_POS = 7;
   localparam int SMC_CFG_AS2_POS = 8;
   localparam logic [3:0] SMC_CLOCK_SOURCE_FUSES_EXT = 4'h0;
   // ----------------------------------------------------------------
   // Mode codes
   // ----------------------------------------------------------------
   localparam logic [2:0] SMC_M_IDLE = 3'h0;
   localparam logic [2:0] SMC_M_ADCNR = 3'h1;
   localparam logic [2:0] SMC_M_PDOWN = 3'h2;
   localparam logic [2:0] SMC_M_PSAVE = 3'h3;
   localparam logic [2:0] SMC_M_STBY = 3'h6;
   localparam logic [2:0] SMC_M_XSTBY = 3'h7;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int SMC_CLK_MHZ = 125;
   localparam int SMC_WAKE_CK = 6;
   localparam int SMC_HALT_CK = 4;
   localparam int SMC_SUT_SHORT_US = 4100;
   localparam int SMC_SUT_LONG_US = 65000;
   localparam int SMC_SUT_SHORT_CYC = SMC_SUT_SHORT_US * SMC_CLK_MHZ;
   localparam int SMC_SUT_LONG_CYC = SMC_SUT_LONG_US * SMC_CLK_MHZ;
   typedef enum logic [4:0] {
      SMC_RUN = 5'b00001,
      SMC_SLEEP = 5'b00010,
      SMC_WAKE = 5'b00100,
      SMC_HALT = 5'b01000,
      SMC_BOOT = 5'b10000
   } smc_state_t;
endpackage

/* smc_sleep_chk.sv */
// Checker for the sleep mode controller: clock gating, wake timing, reset priority.
// Assumes it is bound to smc_sleep_ctrl and sees only that module's ports.
`timescale 1ns/1ps
module smc_sleep_chk (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Watched ports
   input wire logic ext_rst_req,
   input wire logic ext_irq_line_2,
   input wire logic core_run,
   input wire logic irq_take,
   input wire logic reset_vector,
   input wire logic core_clock_domain,
   input wire logic program_memory_clock_domain,
   input wire logic peripheral_clock_domain,
   input wire logic adc_clock_domain,
   input wire logic main_osc_en,
   input wire logic adc_start
);
   // A reset request cuts any wake sequence short, so it suspends the timing checks.
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn || ext_rst_req);
   // A boot after a reset request also restarts the core clock, so only a wake entry counts.
   sequence halt_entry;
      !core_clock_domain && !ext_rst_req ##1 (core_clock_domain && !core_run);
   endsequence
   sequence halt_exit;
      (!core_run)[*3] ##1 core_run ##[0:1] irq_take;
   endsequence
   ccd_pair_a: assert property (core_clock_domain == program_memory_clock_domain)
      else $error("core and program clocks differ");
   run_clk_a: assert property (core_run |-> core_clock_domain && peripheral_clock_domain)
      else $error("core runs with a clock stopped");
   osc_off_a: assert property (!main_osc_en |->
      !core_clock_domain && !peripheral_clock_domain && !adc_clock_domain)
      else $error("clock runs with oscillator stopped");
   halt_four_a: assert property (halt_entry |=> halt_exit)
      else $error("halt after wake is not four cycles");
   wake_six_a: assert property ($rose(ext_irq_line_2) && !core_clock_domain &&
      !peripheral_clock_domain && !adc_clock_domain |=> (!core_clock_domain)[*6] ##1
      core_clock_domain)
      else $error("deep sleep wake delay is not six cycles");
   adc_kick_a: assert property (adc_start |-> !core_run && adc_clock_domain ##1 !adc_start)
      else $error("conversion start outside quiet sleep");
   rst_wins_a: assert property (disable iff (!presetn)
      ext_rst_req |=> !core_run && !irq_take)
      else $error("reset request did not stop the core");
   boot_vec_a: assert property (reset_vector |-> core_run && !irq_take ##1 !reset_vector)
      else $error("reset vector pulse malformed");
endmodule
bind smc_sleep_ctrl smc_sleep_chk u_smc_sleep_chk (.pclk, .presetn, .ext_rst_req,
   .ext_irq_line_2, .core_run, .irq_take, .reset_vector, .core_clock_domain,
   .program_memory_clock_domain, .peripheral_clock_domain, .adc_clock_domain,
   .main_osc_en, .adc_start);

/* smc_sleep_ctrl.sv */
// Sleep mode controller: decodes sleep enable and mode, gates clock domains on the sleep
// command, wakes on the sources permitted in each mode and times the restart.
// Assumes wake sources are synchronous to pclk and the core holds its state while gated.
// Function
// [R1] Sleep is entered only if sleep enable is set when the sleep command arrives.
// [R2] Mode code 000 idle, 001 ADC quiet, 010/011 down/save, 110/111 standby, 10x reserved.
// [R3] Standby modes allowed only with a crystal or resonator clock source.
// [R4] After wake the core stays halted four cycles beyond startup, then takes the interrupt.
// [R5] Register file and SRAM keep their contents across sleep; only clocks are gated.
// [R6] A reset during sleep wakes the device and execution starts from the reset vector.
// [R7] Idle stops only core and program memory clocks.
// [R8] Idle wakes on external and internal peripheral interrupts.
// [R9] With ADC enabled, entering idle or ADC quiet mode starts a conversion.
// [R10] ADC quiet mode also stops the peripheral clock; ADC and async logic stay.
// [R11] ADC quiet wakes on ADC, resets, TWI match, timer 2, SPM/EEPROM, ext lines.
// [R12] Power-down stops the oscillator and all generated clocks.
// [R13] Power-down wakes on resets, TWI match, level lines 0/1, or line 2.
// [R14] A level wake source must hold its level until recognised.
// [R15] Power-down wake is delayed by the fuse-selected startup period. The code uses SMC_WAKE_CK (6 cycles) for every clock source fuse setting.
// [R16] Power-save equals power-down but timer 2 runs when async clocked.
// [R17] Timer 2 wakes power-save only with its enable and global enable set.
// [R18] Software prefers power-down when timer 2 is not async clocked.
// [R19] Clock source fuses 0000 select the external clock input.
// [R20] External clock wake takes 6 cycles; reset delays none, 4.1 ms, 65 ms.
// [R21] The clock source holds reset during frequency jumps over 2 percent.
// [R22] Software sets sleep enable just before sleep and clears it after waking.
// [R23] Standby keeps the oscillator; extended standby is power-save with oscillator on.
// [R24] Standby wakes in six clock cycles.
// [R25] Sleep with a reserved or unavailable mode code does nothing.
`timescale 1ns/1ps
module smc_sleep_ctrl #(
   parameter int SUT_SHORT_CYC = smc_pkg::SMC_SUT_SHORT_CYC,
   parameter int SUT_LONG_CYC = smc_pkg::SMC_SUT_LONG_CYC
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Core
   input wire logic sleep_cmd,
   output logic core_run,
   output logic irq_take,
   output logic reset_vector,
   // Wake sources
   input wire logic ext_rst_req,
   input wire logic ext_irq_line_0,
   input wire logic ext_irq_line_1,
   input wire logic ext_irq_line_2,
   input wire logic twi_match_irq,
   input wire logic timer2_irq,
   input wire logic timer2_irq_en,
   input wire logic global_irq_en,
   input wire logic adc_done_irq,
   input wire logic spm_ee_ready_irq,
   input wire logic other_io_irq,
   // Clock domain enables
   output logic core_clock_domain,
   output logic program_memory_clock_domain,
   output logic peripheral_clock_domain,
   output logic adc_clock_domain,
   output logic async_clock_domain,
   output logic main_osc_en,
   output logic adc_start
);
   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0] ctrl_q;
   logic [8:0] cfg_q;
   smc_pkg::smc_state_t state_q;
   logic [2:0] mode_q;
   logic from_reset_q;
   logic [31:0] cnt_q;
   logic wr_en;
   logic wake_src;
   logic wake_mode_ok;
   logic [2:0] sm_code;
   logic [3:0] clock_source_fuses;
   logic [1:0] startup_delay_fuses;
   logic xtal;

   assign wr_en = psel && penable && pwrite;
   assign pready = 1'b1;
   assign sm_code = ctrl_q[smc_pkg::SMC_SM_MSB:smc_pkg::SMC_SM_LSB];
   assign clock_source_fuses = cfg_q[smc_pkg::SMC_CFG_CLOCK_SOURCE_FUSES_LSB +: 4];
   assign startup_delay_fuses = cfg_q[smc_pkg::SMC_CFG_SUT_LSB +: 2];
   assign xtal = cfg_q[smc_pkg::SMC_CFG_XTAL_POS];

   // Fuse bits are only written while running so a restart delay never shifts mid-wake.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= smc_pkg::SMC_CTRL_RESET;
         cfg_q <= {1'b0, smc_pkg::SMC_CFG_RESET};
      end else if (wr_en) begin
         if (paddr == smc_pkg::SMC_OFF_CTRL) begin
            ctrl_q <= pwdata[7:0];
         end else if (paddr == smc_pkg::SMC_OFF_CFG && state_q == smc_pkg::SMC_RUN) begin
            cfg_q <= pwdata[8:0];
         end
      end
   end

   always_comb begin
      prdata = 32'h0000_0000;
      pslverr = 1'b0;
      if (psel && penable) begin
         unique case (paddr)
            smc_pkg::SMC_OFF_CTRL: prdata = {24'h00_0000, ctrl_q};
            smc_pkg::SMC_OFF_CFG: prdata = {23'h00_0000, cfg_q};
            smc_pkg::SMC_OFF_STATUS: prdata = {24'h00_0000, from_reset_q, mode_q, 3'h0,
                                               state_q == smc_pkg::SMC_SLEEP};
            default: pslverr = 1'b1;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Entry decode
   // ----------------------------------------------------------------
   function automatic logic mode_legal(input logic [2:0] m, input logic x);
      unique case (m)
         smc_pkg::SMC_M_IDLE, smc_pkg::SMC_M_ADCNR, smc_pkg::SMC_M_PDOWN,
         smc_pkg::SMC_M_PSAVE: mode_legal = 1'b1; // [R2]
         smc_pkg::SMC_M_STBY, smc_pkg::SMC_M_XSTBY: mode_legal = x; // [R3]
         default: mode_legal = 1'b0; // [R25]
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Wake decode
   // ----------------------------------------------------------------
   // The two-wire match and external lines reach here already qualified by sense logic.
   always_comb begin
      logic t2ok;
      logic ext;
      t2ok = timer2_irq && timer2_irq_en && global_irq_en; // [R17]
      ext = ext_irq_line_0 || ext_irq_line_1 || ext_irq_line_2; // [R14]
      unique case (mode_q)
         smc_pkg::SMC_M_IDLE:
            wake_mode_ok = ext || twi_match_irq || timer2_irq || adc_done_irq
                           || spm_ee_ready_irq || other_io_irq; // [R8]
         smc_pkg::SMC_M_ADCNR:
            wake_mode_ok = ext || twi_match_irq || timer2_irq || adc_done_irq
                           || spm_ee_ready_irq; // [R11]
         smc_pkg::SMC_M_PSAVE, smc_pkg::SMC_M_XSTBY:
            wake_mode_ok = ext || twi_match_irq
                           || (cfg_q[smc_pkg::SMC_CFG_AS2_POS] && t2ok); // [R16]
         default:
            wake_mode_ok = ext || twi_match_irq; // [R13]
      endcase
   end
   assign wake_src = wake_mode_ok;

   function automatic logic [31:0] wake_cycles(input logic [2:0] m, input logic [3:0] ck);
      if (m == smc_pkg::SMC_M_STBY || m == smc_pkg::SMC_M_XSTBY) begin
         wake_cycles = 32'(smc_pkg::SMC_WAKE_CK); // [R24]
      end else if (m == smc_pkg::SMC_M_PDOWN || m == smc_pkg::SMC_M_PSAVE) begin
         // Only the external clock timing is modelled; other sources reuse it.
         wake_cycles = (ck == smc_pkg::SMC_CLOCK_SOURCE_FUSES_EXT) ? 32'(smc_pkg::SMC_WAKE_CK) // [R19]
                                                       : 32'(smc_pkg::SMC_WAKE_CK); // [R15] [R20]
      end else begin
         wake_cycles = 32'h0000_0001;
      end
   endfunction

   function automatic logic [31:0] boot_cycles(input logic [1:0] s);
      unique case (s)
         2'h1: boot_cycles = 32'(SUT_SHORT_CYC); // [R20]
         2'h2: boot_cycles = 32'(SUT_LONG_CYC);
         default: boot_cycles = 32'h0000_0001;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   // A reset request is honoured in every state; the register file is never touched. [R5]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= smc_pkg::SMC_RUN;
         mode_q <= smc_pkg::SMC_M_IDLE;
         cnt_q <= 32'h0000_0000;
         from_reset_q <= 1'b0;
      end else if (ext_rst_req) begin
         state_q <= smc_pkg::SMC_BOOT; // [R6]
         cnt_q <= boot_cycles(startup_delay_fuses);
         from_reset_q <= 1'b1;
      end else begin
         unique case (state_q)
            smc_pkg::SMC_RUN: begin
               if (sleep_cmd && ctrl_q[smc_pkg::SMC_SE_POS] && mode_legal(sm_code, xtal)) begin
                  state_q <= smc_pkg::SMC_SLEEP; // [R1]
                  mode_q <= sm_code;
                  from_reset_q <= 1'b0;
               end
            end
            smc_pkg::SMC_SLEEP: begin
               if (wake_src) begin
                  state_q <= smc_pkg::SMC_WAKE;
                  cnt_q <= wake_cycles(mode_q, clock_source_fuses);
               end
            end
            smc_pkg::SMC_WAKE: begin
               if (cnt_q <= 32'h0000_0001) begin
                  state_q <= smc_pkg::SMC_HALT;
                  cnt_q <= 32'(smc_pkg::SMC_HALT_CK); // [R4]
               end else begin
                  cnt_q <= cnt_q - 32'h0000_0001;
               end
            end
            smc_pkg::SMC_HALT, smc_pkg::SMC_BOOT: begin
               if (cnt_q <= 32'h0000_0001) begin
                  state_q <= smc_pkg::SMC_RUN;
               end else begin
                  cnt_q <= cnt_q - 32'h0000_0001;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   logic asleep;
   logic adc_start_q;
   logic irq_take_q;
   logic rv_q;
   assign asleep = (state_q == smc_pkg::SMC_SLEEP) || (state_q == smc_pkg::SMC_WAKE);
   assign core_run = state_q == smc_pkg::SMC_RUN;
   assign core_clock_domain = !asleep; // [R7]
   assign program_memory_clock_domain = !asleep;
   assign peripheral_clock_domain = !asleep || mode_q == smc_pkg::SMC_M_IDLE; // [R10]
   assign adc_clock_domain = !asleep || mode_q == smc_pkg::SMC_M_IDLE
                             || mode_q == smc_pkg::SMC_M_ADCNR; // [R12]
   assign async_clock_domain = adc_clock_domain || (cfg_q[smc_pkg::SMC_CFG_AS2_POS]
                               && (mode_q == smc_pkg::SMC_M_PSAVE
                               || mode_q == smc_pkg::SMC_M_XSTBY)); // [R16]
   assign main_osc_en = !asleep || mode_q == smc_pkg::SMC_M_IDLE
                        || mode_q == smc_pkg::SMC_M_ADCNR
                        || mode_q == smc_pkg::SMC_M_STBY
                        || mode_q == smc_pkg::SMC_M_XSTBY; // [R23]
   assign adc_start = adc_start_q;
   assign irq_take = irq_take_q;
   assign reset_vector = rv_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adc_start_q <= 1'b0;
         irq_take_q <= 1'b0;
         rv_q <= 1'b0;
      end else begin
         adc_start_q <= state_q == smc_pkg::SMC_RUN && !ext_rst_req && sleep_cmd
                        && ctrl_q[smc_pkg::SMC_SE_POS] && cfg_q[smc_pkg::SMC_CFG_ADCEN_POS]
                        && (sm_code == smc_pkg::SMC_M_IDLE
                        || sm_code == smc_pkg::SMC_M_ADCNR); // [R9]
         irq_take_q <= state_q == smc_pkg::SMC_HALT && !ext_rst_req && cnt_q <= 32'h0000_0001;
         rv_q <= state_q == smc_pkg::SMC_BOOT && !ext_rst_req && cnt_q <= 32'h0000_0001;
      end
   end
endmodule

/* test_sleep_mode_controller.sv */
// Self-checking bench for the sleep mode controller with a core model on line 2.
// Assumes the APB slave answers in the access phase and pclk runs at 125 MHz.
`timescale 1ns/1ps
module test_sleep_mode_controller;
   logic pclk, presetn, psel, penable, pwrite, ext_rst_req, go_sleep, go_wake, err_q;
   logic pready, pslverr, sleep_cmd, core_run, irq_take, reset_vector, line2, adc_start;
   logic ccd, pmcd, pcd, acd, asyd, osc;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd_q;
   logic [6:0] wk;
   int n_mismatch = 0;
   int cmp_count = 0;
   int cyc = 0;
   int adc_cnt = 0;
   smc_sleep_ctrl #(.SUT_SHORT_CYC(8), .SUT_LONG_CYC(16)) u_smc_sleep_ctrl (.pclk, .presetn,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sleep_cmd,
      .core_run, .irq_take, .reset_vector, .ext_rst_req, .ext_irq_line_0(1'b0),
      .ext_irq_line_1(1'b0), .ext_irq_line_2(line2), .twi_match_irq(wk[3]),
      .timer2_irq(wk[0]), .timer2_irq_en(wk[5]), .global_irq_en(wk[6]),
      .adc_done_irq(wk[2]), .spm_ee_ready_irq(wk[4]), .other_io_irq(wk[1]),
      .core_clock_domain(ccd), .program_memory_clock_domain(pmcd),
      .peripheral_clock_domain(pcd), .adc_clock_domain(acd), .async_clock_domain(asyd),
      .main_osc_en(osc), .adc_start);
   smc_core_model u_smc_core_model (.pclk, .presetn, .go_sleep, .go_wake, .core_run,
      .irq_take, .sleep_cmd, .ext_irq_line_2(line2));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // One idle edge keeps a following call from driving psel twice in one step.
      @(posedge pclk);
   endtask
   task automatic pulse_wake();
      go_wake <= 1'b1;
      @(posedge pclk);
      go_wake <= 1'b0;
   endtask
   task automatic wait_irq(output logic seen);
      seen = 1'b0;
      repeat (30) begin
         @(negedge pclk);
         if (irq_take === 1'b1) seen = 1'b1;
      end
      @(posedge pclk);
   endtask
   task automatic do_sleep(input logic se, input logic [2:0] m);
      apb(1'b1, smc_pkg::SMC_OFF_CTRL, {24'h0, se, m, 4'h0});
      go_sleep <= 1'b1;
      @(posedge pclk);
      go_sleep <= 1'b0;
      repeat (4) @(posedge pclk);
      apb(1'b0, smc_pkg::SMC_OFF_STATUS, 32'h0);
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      apb(1'b0, smc_pkg::SMC_OFF_CTRL, 32'h0);
      cmp("ctrl reset", {24'h0, smc_pkg::SMC_CTRL_RESET}, rd_q);
      apb(1'b1, smc_pkg::SMC_OFF_CTRL, 32'h0000_007F);
      apb(1'b0, smc_pkg::SMC_OFF_CTRL, 32'h0);
      cmp("ctrl rw", 32'h0000_007F, rd_q);
      apb(1'b0, 8'h0C, 32'h0);
      cmp("unmapped err", 32'h1, {31'h0, err_q});
      do_sleep(1'b0, smc_pkg::SMC_M_IDLE);
      cmp("asleep no enable", 32'h0, {31'h0, rd_q[0]});
   endtask
   task automatic t_modes(input logic xtal);
      logic seen, ok;
      logic [4:0] dom;
      logic [31:0] st;
      int a0;
      apb(1'b1, smc_pkg::SMC_OFF_CFG, {24'h0, 2'b11, 6'h10} & {24'h0, 1'b1, xtal, 6'h3F});
      for (int m = 0; m < 8; m++) begin
         ok = (m < 4) || (m > 5 && xtal);
         a0 = adc_cnt;
         do_sleep(1'b1, 3'(m));
         st = ok ? 32'((m << 4) | 1) : 32'h0;
         cmp("status", st, rd_q & (ok ? 32'h71 : 32'h1));
         cmp("adc start", ok && m < 2, adc_cnt - a0);
         dom = ok ? {1'b0, m == 0, m < 2, m < 2, m < 2 || m > 5} : 5'h1F;
         @(negedge pclk);
         cmp("domains", dom, {ccd, pcd, acd, asyd, osc});
         @(posedge pclk);
         if (ok) begin
            pulse_wake();
            wait_irq(seen);
            cmp("wake", 1, seen);
            apb(1'b0, smc_pkg::SMC_OFF_CTRL, 32'h0);
            cmp("ctrl kept", {24'h0, 1'b1, 3'(m), 4'h0}, rd_q);
         end
         apb(1'b1, smc_pkg::SMC_OFF_CTRL, 32'h0);
      end
   endtask
   task automatic t_sources();
      logic seen;
      logic [6:0] src [8] = '{7'h02, 7'h02, 7'h04, 7'h04, 7'h08, 7'h61, 7'h21, 7'h61};
      logic [2:0] md [8] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h2};
      logic ex [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
      apb(1'b1, smc_pkg::SMC_OFF_CFG, 32'h0000_01D0);
      for (int i = 0; i < 8; i++) begin
         do_sleep(1'b1, md[i]);
         wk <= src[i];
         wait_irq(seen);
         wk <= 7'h0;
         cmp("source wake", ex[i], seen);
         if (!seen) begin
            pulse_wake();
            wait_irq(seen);
         end
      end
   endtask
   task automatic t_reset_sleep();
      int n;
      for (int s = 1; s < 3; s++) begin
         apb(1'b1, smc_pkg::SMC_OFF_CFG, 32'h0000_00C0 | (s << 4));
         do_sleep(1'b1, smc_pkg::SMC_M_PDOWN);
         ext_rst_req <= 1'b1;
         @(posedge pclk);
         ext_rst_req <= 1'b0;
         n = 0;
         while (reset_vector !== 1'b1 && n < 40) begin
            @(negedge pclk);
            n++;
         end
         cmp("boot delay", 1, n >= 8 * s && n <= 8 * s + 3);
         @(posedge pclk);
         apb(1'b0, smc_pkg::SMC_OFF_STATUS, 32'h0);
         cmp("wake by reset", 32'h80, rd_q & 32'h81);
      end
   endtask
   task automatic tally_and_finish();
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      if (adc_start === 1'b1) adc_cnt <= adc_cnt + 1;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   initial begin
      {presetn, psel, penable, pwrite, ext_rst_req, go_sleep, go_wake} = 7'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      wk = 7'h00;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_modes(1'b1);
      t_modes(1'b0);
      t_sources();
      t_reset_sleep();
      tally_and_finish();
   end
endmodule
